// ### hdl/afe_dev_end.sv
`default_nettype none
// Behaviour
// RL1: Code 0x2006 checksums configuration into 0x25.
// RL2: Code 0x2007 checksums coefficients into 0x26.
// RL3: Code 0x2008 checksums factory trim into 0x27.
// RL4: Host waits ready or 64 clocks.
// RL5: Ready pulse after checksum, within 64 clocks.
// RL6: Read instruction is 0x2000 plus address.
// RL7: Write instruction is address, then data.
// RL8: Conversion stored in channel data, ready rises.
// RL9: Direct readback shifts result while select low.
// RL10: Host may read channel data register instead.
// RL11: Ready pulse two clocks, eight when selected.
// RL12: Channel configuration reached through channel pointer.
// RL13: Sixteen channels, pointer shown in status.
// RL14: Registers 16 bits, data registers 24.
// RL15: Configuration 0 bits 15:12 positive input.
// RL16: Bits 11:8 negative input, same codes.
// RL17: Bits 7:5 select gain 0.2x to 16x.
// RL18: Bit 4 selects high-voltage or internal pair.
// RL19: Bits 3:1 select internal signal pair.
// RL20: Bit 0 set disables tempco correction.
// RL21: Configuration 1 bits 15:12 calibration pair.
// RL22: Configuration 1 bits 11:8 threshold set.
// RL23: Channel select is codes 0x0000 to 0x000F.
module afe_dev_end (
  input wire logic i_mclk,
  input wire logic i_rstn,
  afe_spi_if.dev spi,
  input wire logic i_conv_valid,
  input wire logic [3:0] i_conv_chan,
  input wire logic [afe_cmd_pkg::DATA_W-1:0] i_conv_data,
  input wire logic [3:0] i_cfg_chan,
  input wire logic [afe_cmd_pkg::DATA_W-1:0] i_coef_word,
  input wire logic [afe_cmd_pkg::REG_W-1:0] i_trim_word,
  output logic o_conv_start,
  output logic [2:0] o_conv_mode,
  output logic [5:0] o_word_idx,
  output logic [3:0] o_ch_ptr,
  output logic [3:0] o_pos_sel,
  output logic [3:0] o_neg_sel,
  output logic [2:0] o_gain_sel,
  output logic o_high_voltage_source_select,
  output logic [2:0] o_lv_sel,
  output logic o_tcc_dis,
  output logic [3:0] o_cal_ptr,
  output logic [3:0] o_thr_sel,
  output logic o_sel_unused
);
  import afe_cmd_pkg::*;

  typedef enum logic [2:0] {
    D_IDLE = 3'b000, D_INSTR = 3'b001, D_DATA = 3'b011, D_DIRECT = 3'b010, D_DONE = 3'b110
  } dev_state_t;

  logic [1:0] cs_s_ff;
  logic [1:0] sck_s_ff;
  logic [1:0] mo_s_ff;
  logic sck_d_ff;
  dev_state_t st_ff;
  logic [4:0] cnt_ff;
  logic [4:0] len_ff;
  logic [23:0] rx_ff;
  logic [23:0] tx_ff;
  logic [15:0] instr_ff;
  logic instr_done_ff;
  logic data_done_ff;
  logic [15:0] cfg0_ff [CHANNELS];
  logic [15:0] cfg1_ff [CHANNELS];
  logic [23:0] data_ff [CHANNELS];
  logic [15:0] sys_ff;
  logic [15:0] ck_res_ff [3];
  logic [3:0] ptr_ff;
  logic ck_busy_ff;
  logic ck_fin_ff;
  logic [5:0] ck_idx_ff;
  ck_kind_t ck_kind_ff;
  logic data_ready_out_ff;
  logic [3:0] data_ready_out_cnt_ff;
  logic [15:0] crc;
  logic [23:0] ck_word;
  logic [23:0] rd_val;
  logic sck_rise;
  logic cs_act;
  logic [15:0] nxt_instr;
  logic [12:0] addr;
  logic [1:0] ck_slot;

  assign sck_rise = sck_s_ff[1] & ~sck_d_ff;
  assign cs_act = ~cs_s_ff[1];
  assign nxt_instr = {rx_ff[14:0], mo_s_ff[1]};
  assign addr = instr_ff[12:0];
  assign ck_slot = (ck_kind_ff == CK_CFG) ? 2'h0 : (ck_kind_ff == CK_COEF) ? 2'h1 : 2'h2;
  assign spi.miso = tx_ff[23];
  assign spi.data_ready_out = data_ready_out_ff;
  assign o_word_idx = ck_idx_ff;
  assign o_ch_ptr = ptr_ff;

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      cs_s_ff <= 2'b11;
      sck_s_ff <= 2'b00;
      mo_s_ff <= 2'b00;
      sck_d_ff <= 1'b0;
    end else begin
      cs_s_ff <= {cs_s_ff[0], spi.chip_select_n};
      sck_s_ff <= {sck_s_ff[0], spi.sclk};
      mo_s_ff <= {mo_s_ff[0], spi.mosi};
      sck_d_ff <= sck_s_ff[1];
    end
  end

  // Frame sequencing: 16-bit instruction, then the data bits it implies.
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_ff <= D_IDLE;
      cnt_ff <= 5'h00;
      len_ff <= 5'h00;
      rx_ff <= 24'h000000;
      instr_ff <= 16'h0000;
      instr_done_ff <= 1'b0;
      data_done_ff <= 1'b0;
    end else begin
      instr_done_ff <= 1'b0;
      data_done_ff <= 1'b0;
      if (!cs_act) begin
        st_ff <= D_IDLE;
      end else begin
        unique case (st_ff)
          D_IDLE: begin
            st_ff <= D_INSTR;
            cnt_ff <= 5'h00;
          end
          D_INSTR: if (sck_rise) begin
            rx_ff <= {rx_ff[22:0], mo_s_ff[1]};
            cnt_ff <= 5'(cnt_ff + 5'h01);
            if (cnt_ff == BITS_INSTR - 5'h01) begin
              instr_ff <= nxt_instr;
              instr_done_ff <= 1'b1;
              len_ff <= data_bits(nxt_instr); // [RL6] [RL7]
              cnt_ff <= 5'h00;
              if (data_bits(nxt_instr) != 5'h00) begin
                st_ff <= D_DATA;
              end else if (nxt_instr[RW_BIT] && nxt_instr[12:0] <= ADDR_CONV_LAST) begin
                st_ff <= D_DIRECT; // [RL9]
              end else begin
                st_ff <= D_DONE;
              end
            end
          end
          D_DATA: if (sck_rise) begin
            rx_ff <= {rx_ff[22:0], mo_s_ff[1]};
            cnt_ff <= 5'(cnt_ff + 5'h01);
            if (cnt_ff == len_ff - 5'h01) begin
              data_done_ff <= 1'b1;
              st_ff <= D_DONE;
            end
          end
          D_DIRECT, D_DONE: begin
          end
        endcase
      end
    end
  end

  always_comb begin
    rd_val = 24'h000000;
    if (is_data_addr(addr)) begin
      rd_val = data_ff[addr[3:0]];
    end else begin
      case (addr)
        ADDR_CFG0: rd_val = {8'h00, cfg0_ff[ptr_ff]}; // [RL12]
        ADDR_CFG1: rd_val = {8'h00, cfg1_ff[ptr_ff]};
        ADDR_CK_CFG: rd_val = {8'h00, ck_res_ff[0]};
        ADDR_CK_COEF: rd_val = {8'h00, ck_res_ff[1]};
        ADDR_CK_TRIM: rd_val = {8'h00, ck_res_ff[2]};
        ADDR_SYSCFG0: rd_val = {8'h00, sys_ff};
        ADDR_STATUS: rd_val = {20'h00000, ptr_ff}; // [RL13]
        default: rd_val = 24'h000000;
      endcase
    end
  end

  // Outgoing bits: a read value is left-aligned in the 24-bit buffer.
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      tx_ff <= 24'h000000;
    end else if (instr_done_ff) begin
      tx_ff <= (len_ff == BITS_DATA) ? rd_val : {rd_val[15:0], 8'h00}; // [RL14]
    end else if (st_ff == D_DIRECT && cs_act && i_conv_valid) begin
      tx_ff <= i_conv_data; // [RL9]
    end else if (sck_rise && (st_ff == D_DATA || st_ff == D_DIRECT)) begin
      tx_ff <= {tx_ff[22:0], 1'b0};
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      ptr_ff <= 4'h0;
      o_conv_start <= 1'b0;
      o_conv_mode <= 3'h0;
    end else begin
      o_conv_start <= 1'b0;
      if (instr_done_ff && !instr_ff[RW_BIT] && addr <= ADDR_CHAN_LAST) begin
        ptr_ff <= addr[3:0]; // [RL23] [RL12]
      end
      if (instr_done_ff && instr_ff[RW_BIT] && addr <= ADDR_CONV_LAST) begin
        o_conv_start <= 1'b1;
        o_conv_mode <= addr[2:0];
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      for (int i = 0; i < CHANNELS; i++) begin
        cfg0_ff[i] <= CFG_RESET;
        cfg1_ff[i] <= CFG_RESET;
      end
      sys_ff <= CFG_RESET;
    end else if (data_done_ff && !instr_ff[RW_BIT]) begin
      case (addr)
        ADDR_CFG0: cfg0_ff[ptr_ff] <= rx_ff[15:0]; // [RL12] [RL7]
        ADDR_CFG1: cfg1_ff[ptr_ff] <= rx_ff[15:0];
        ADDR_SYSCFG0: sys_ff <= rx_ff[15:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      for (int i = 0; i < CHANNELS; i++) begin
        data_ff[i] <= 24'h000000;
      end
    end else if (i_conv_valid) begin
      data_ff[i_conv_chan] <= i_conv_data; // [RL8]
    end
  end

  // Checksum walk: one word per clock, so the longest walk ends well inside 64 clocks.
  always_comb begin
    ck_word = 24'h000000;
    unique case (ck_kind_ff)
      CK_CFG: begin
        if (ck_idx_ff < 6'h10) ck_word = {8'h00, cfg0_ff[ck_idx_ff[3:0]]}; // [RL1]
        else if (ck_idx_ff < CFG_LAST) ck_word = {8'h00, cfg1_ff[ck_idx_ff[3:0]]};
        else ck_word = {8'h00, sys_ff};
      end
      CK_COEF: ck_word = i_coef_word; // [RL2]
      CK_TRIM: ck_word = {8'h00, i_trim_word}; // [RL3]
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      ck_busy_ff <= 1'b0;
      ck_fin_ff <= 1'b0;
      ck_kind_ff <= CK_CFG;
      ck_idx_ff <= 6'h00;
    end else begin
      ck_fin_ff <= 1'b0;
      if (!ck_busy_ff && instr_done_ff && instr_ff[RW_BIT] && addr >= ADDR_CK_FIRST
          && addr <= ADDR_RDCMD_LAST) begin
        ck_busy_ff <= 1'b1;
        ck_idx_ff <= 6'h00;
        ck_kind_ff <= (instr_ff == CMD_CK_CFG) ? CK_CFG : (instr_ff == CMD_CK_COEF) ? CK_COEF : CK_TRIM;
      end else if (ck_busy_ff) begin
        ck_idx_ff <= 6'(ck_idx_ff + 6'h01);
        if (ck_idx_ff == ((ck_kind_ff == CK_CFG) ? CFG_LAST : (ck_kind_ff == CK_COEF) ? COEF_LAST : TRIM_LAST)) begin
          ck_busy_ff <= 1'b0;
          ck_fin_ff <= 1'b1;
        end
      end
    end
  end

  crc16_engine u_crc (
    .i_mclk(i_mclk),
    .i_rstn(i_rstn),
    .i_clear(~ck_busy_ff),
    .i_valid(ck_busy_ff),
    .i_wide(ck_kind_ff == CK_COEF),
    .i_word(ck_word),
    .o_crc(crc)
  );

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      for (int i = 0; i < 3; i++) begin
        ck_res_ff[i] <= 16'h0000;
      end
    end else if (ck_fin_ff) begin
      ck_res_ff[ck_slot] <= crc; // [RL1] [RL2] [RL3]
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      data_ready_out_ff <= 1'b0;
      data_ready_out_cnt_ff <= 4'h0;
    end else if (ck_fin_ff || i_conv_valid) begin
      data_ready_out_ff <= 1'b1; // [RL5] [RL8]
      data_ready_out_cnt_ff <= (sys_ff[SYS_PW_BIT] ? DATA_READY_OUT_LONG : DATA_READY_OUT_SHORT) - 4'h1; // [RL11]
    end else if (data_ready_out_cnt_ff != 4'h0) begin
      data_ready_out_cnt_ff <= 4'(data_ready_out_cnt_ff - 4'h1);
    end else begin
      data_ready_out_ff <= 1'b0;
    end
  end

  // Field decode for the channel the converter is working on.
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_pos_sel <= 4'h0;
      o_neg_sel <= 4'h0;
      o_gain_sel <= 3'h0;
      o_high_voltage_source_select <= 1'b0;
      o_lv_sel <= 3'h0;
      o_tcc_dis <= 1'b0;
      o_cal_ptr <= 4'h0;
      o_thr_sel <= 4'h0;
      o_sel_unused <= 1'b0;
    end else begin
      o_pos_sel <= cfg0_ff[i_cfg_chan][F_POS_MSB:F_POS_LSB]; // [RL15]
      o_neg_sel <= cfg0_ff[i_cfg_chan][F_NEG_MSB:F_NEG_LSB]; // [RL16]
      o_gain_sel <= cfg0_ff[i_cfg_chan][F_GAIN_MSB:F_GAIN_LSB]; // [RL17]
      o_high_voltage_source_select <= cfg0_ff[i_cfg_chan][F_HV_BIT]; // [RL18]
      o_lv_sel <= cfg0_ff[i_cfg_chan][F_LV_MSB:F_LV_LSB]; // [RL19]
      o_tcc_dis <= cfg0_ff[i_cfg_chan][F_TCC_BIT]; // [RL20]
      o_cal_ptr <= cfg1_ff[i_cfg_chan][F_CAL_MSB:F_CAL_LSB]; // [RL21]
      o_thr_sel <= cfg1_ff[i_cfg_chan][F_THR_MSB:F_THR_LSB]; // [RL22]
      o_sel_unused <= cfg0_ff[i_cfg_chan][F_HV_BIT]
                      ? (cfg0_ff[i_cfg_chan][F_POS_MSB] | cfg0_ff[i_cfg_chan][F_NEG_MSB])
                      : (cfg0_ff[i_cfg_chan][F_LV_MSB:F_LV_LSB] > LV_LAST); // [RL15] [RL16] [RL19]
    end
  end
endmodule // afe_dev_end
`default_nettype wire

// ### hdl/afe_cmd_pkg.sv
`default_nettype none
package afe_cmd_pkg;
  localparam int CLK_MHZ = 100;
  localparam int DATA_W = 24;
  localparam int REG_W = 16;
  localparam int CHANNELS = 16;
  localparam int RW_BIT = 13;
  localparam logic [12:0] ADDR_CMD_LAST = 13'h001F;
  localparam logic [12:0] ADDR_RDCMD_LAST = 13'h0008;
  localparam logic [12:0] ADDR_CHAN_LAST = 13'h000F;
  localparam logic [12:0] ADDR_CONV_LAST = 13'h0004;
  localparam logic [12:0] ADDR_CK_FIRST = 13'h0006;
  localparam logic [12:0] ADDR_CFG0 = 13'h0020;
  localparam logic [12:0] ADDR_CFG1 = 13'h0021;
  localparam logic [12:0] ADDR_CK_CFG = 13'h0025;
  localparam logic [12:0] ADDR_CK_COEF = 13'h0026;
  localparam logic [12:0] ADDR_CK_TRIM = 13'h0027;
  localparam logic [12:0] ADDR_SYSCFG0 = 13'h0030;
  localparam logic [12:0] ADDR_STATUS = 13'h0031;
  localparam logic [12:0] ADDR_DATA0 = 13'h0040;
  localparam logic [15:0] INSTR_RD = 16'h2000;
  localparam logic [15:0] INSTR_WR = 16'h0000;
  localparam logic [15:0] CMD_CK_CFG = 16'h2006;
  localparam logic [15:0] CMD_CK_COEF = 16'h2007;
  localparam logic [15:0] CMD_CK_TRIM = 16'h2008;
  localparam int SYS_PW_BIT = 15;
  localparam int F_POS_MSB = 15;
  localparam int F_POS_LSB = 12;
  localparam int F_NEG_MSB = 11;
  localparam int F_NEG_LSB = 8;
  localparam int F_GAIN_MSB = 7;
  localparam int F_GAIN_LSB = 5;
  localparam int F_HV_BIT = 4;
  localparam int F_LV_MSB = 3;
  localparam int F_LV_LSB = 1;
  localparam int F_TCC_BIT = 0;
  localparam int F_CAL_MSB = 15;
  localparam int F_CAL_LSB = 12;
  localparam int F_THR_MSB = 11;
  localparam int F_THR_LSB = 8;
  localparam logic [2:0] LV_LAST = 3'h5;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam logic [3:0] DATA_READY_OUT_SHORT = 4'h2;
  localparam logic [3:0] DATA_READY_OUT_LONG = 4'h8;
  localparam int CK_WAIT_CYC = 64;
  localparam logic [5:0] CFG_LAST = 6'h20;
  localparam logic [5:0] COEF_LAST = 6'h2F;
  localparam logic [5:0] TRIM_LAST = 6'h0F;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [3:0] SCLK_HALF = 4'h8;
  localparam logic [4:0] BITS_INSTR = 5'h10;
  localparam logic [4:0] BITS_REG = 5'h10;
  localparam logic [4:0] BITS_DATA = 5'h18;
  typedef enum logic [1:0] {CK_CFG = 2'b00, CK_COEF = 2'b01, CK_TRIM = 2'b11} ck_kind_t;

  function automatic logic is_data_addr(input logic [12:0] a);
    return a[12:4] == ADDR_DATA0[12:4];
  endfunction

  // Number of data bits that follow an instruction word.
  function automatic logic [4:0] data_bits(input logic [15:0] instr);
    logic [12:0] a;
    a = instr[12:0];
    if (!instr[RW_BIT] && a <= ADDR_CMD_LAST) return 5'h00;
    if (instr[RW_BIT] && a <= ADDR_RDCMD_LAST) return 5'h00;
    return is_data_addr(a) ? BITS_DATA : BITS_REG;
  endfunction
endpackage
`default_nettype wire

// ### hdl/afe_spi_if.sv
`default_nettype none
interface afe_spi_if;
  logic chip_select_n;
  logic sclk;
  logic mosi;
  logic miso;
  logic data_ready_out;
  modport dev (input chip_select_n, input sclk, input mosi, output miso, output data_ready_out);
  modport host (output chip_select_n, output sclk, output mosi, input miso, input data_ready_out);
endinterface
`default_nettype wire

// ### hdl/crc16_engine.sv
`default_nettype none
module crc16_engine (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_clear,
  input wire logic i_valid,
  input wire logic i_wide,
  input wire logic [afe_cmd_pkg::DATA_W-1:0] i_word,
  output logic [15:0] o_crc
);
  import afe_cmd_pkg::*;

  // Folds a word in MSB first; a narrow word uses only its low 16 bits.
  function automatic logic [15:0] crc_word(input logic [15:0] c, input logic [23:0] w, input logic wide);
    logic [15:0] r;
    logic fb;
    r = c;
    for (int i = 23; i >= 0; i--) begin
      if (wide || i < 16) begin
        fb = r[15] ^ w[i];
        r = {r[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
      end
    end
    return r;
  endfunction

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_crc <= CRC_INIT;
    end else if (i_clear) begin
      o_crc <= CRC_INIT;
    end else if (i_valid) begin
      o_crc <= crc_word(o_crc, i_word, i_wide);
    end
  end
endmodule // crc16_engine
`default_nettype wire

// ### hdl/afe_host_end.sv
`default_nettype none
module afe_host_end (
  input wire logic i_mclk,
  input wire logic i_rstn,
  afe_spi_if.host spi,
  input wire logic i_req,
  input wire logic [15:0] i_instr,
  input wire logic [afe_cmd_pkg::DATA_W-1:0] i_wdata,
  output logic o_ready,
  output logic o_done,
  output logic [afe_cmd_pkg::DATA_W-1:0] o_rdata
);
  import afe_cmd_pkg::*;

  typedef enum logic [2:0] {
    H_IDLE = 3'b000, H_SHIFT = 3'b001, H_WAIT = 3'b011, H_GAP = 3'b010
  } host_state_t;

  host_state_t st_ff;
  logic [3:0] div_ff;
  logic [1:0] mi_s_ff;
  logic [1:0] dr_s_ff;
  logic dr_d_ff;
  logic cs_n_ff;
  logic sclk_ff;
  logic [39:0] tx_ff;
  logic [23:0] rx_ff;
  logic [5:0] bits_ff;
  logic [5:0] cnt_ff;
  logic [4:0] nb_ff;
  logic [15:0] instr_ff;
  logic direct_ff;
  logic [6:0] wait_ff;
  logic tick;
  logic dr_rise;
  logic is_conv;
  logic is_ck;

  assign tick = (div_ff == SCLK_HALF - 4'h1);
  assign dr_rise = dr_s_ff[1] & ~dr_d_ff;
  assign is_conv = instr_ff[RW_BIT] && instr_ff[12:0] <= ADDR_CONV_LAST;
  assign is_ck = instr_ff[RW_BIT] && instr_ff[12:0] >= ADDR_CK_FIRST && instr_ff[12:0] <= ADDR_RDCMD_LAST;
  assign spi.chip_select_n = cs_n_ff;
  assign spi.sclk = sclk_ff;
  assign spi.mosi = tx_ff[39];

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      mi_s_ff <= 2'b00;
      dr_s_ff <= 2'b00;
      dr_d_ff <= 1'b0;
      div_ff <= 4'h0;
    end else begin
      mi_s_ff <= {mi_s_ff[0], spi.miso};
      dr_s_ff <= {dr_s_ff[0], spi.data_ready_out};
      dr_d_ff <= dr_s_ff[1];
      div_ff <= tick ? 4'h0 : 4'(div_ff + 4'h1);
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_ff <= H_IDLE;
      cs_n_ff <= 1'b1;
      sclk_ff <= 1'b0;
      tx_ff <= 40'h0000000000;
      rx_ff <= 24'h000000;
      bits_ff <= 6'h00;
      cnt_ff <= 6'h00;
      nb_ff <= 5'h00;
      instr_ff <= 16'h0000;
      direct_ff <= 1'b0;
      wait_ff <= 7'h00;
      o_ready <= 1'b0;
      o_done <= 1'b0;
      o_rdata <= 24'h000000;
    end else begin
      o_done <= 1'b0;
      unique case (st_ff)
        H_IDLE: begin
          o_ready <= 1'b1;
          if (i_req && o_ready && tick) begin
            o_ready <= 1'b0;
            instr_ff <= i_instr; // [RL6] [RL7] [RL23]
            nb_ff <= data_bits(i_instr);
            tx_ff <= (data_bits(i_instr) == BITS_DATA) ? {i_instr, i_wdata} : {i_instr, i_wdata[15:0], 8'h00};
            bits_ff <= 6'(BITS_INSTR) + 6'(data_bits(i_instr));
            cnt_ff <= 6'h00;
            direct_ff <= 1'b0;
            cs_n_ff <= 1'b0;
            st_ff <= H_SHIFT;
          end
        end
        H_SHIFT: if (tick) begin
          if (!sclk_ff && cnt_ff != bits_ff) begin
            sclk_ff <= 1'b1;
            rx_ff <= {rx_ff[22:0], mi_s_ff[1]};
            cnt_ff <= 6'(cnt_ff + 6'h01);
          end else if (sclk_ff) begin
            sclk_ff <= 1'b0;
            tx_ff <= {tx_ff[38:0], 1'b0};
          end else if (is_conv && !direct_ff) begin
            wait_ff <= 7'h00;
            st_ff <= H_WAIT; // [RL9]
          end else begin
            cs_n_ff <= 1'b1;
            wait_ff <= 7'h00;
            o_rdata <= (direct_ff || nb_ff == BITS_DATA) ? rx_ff : {8'h00, rx_ff[15:0]}; // [RL10]
            st_ff <= is_ck ? H_WAIT : H_GAP;
          end
        end
        H_WAIT: begin
          wait_ff <= 7'(wait_ff + 7'h01);
          if (is_conv) begin
            if (dr_rise) begin
              tx_ff <= 40'h0000000000;
              bits_ff <= 6'(BITS_DATA);
              cnt_ff <= 6'h00;
              direct_ff <= 1'b1;
              st_ff <= H_SHIFT; // [RL9]
            end
          end else if (dr_rise || wait_ff == 7'(CK_WAIT_CYC - 1)) begin
            st_ff <= H_GAP; // [RL4]
          end
        end
        H_GAP: if (tick) begin
          o_done <= 1'b1;
          st_ff <= H_IDLE;
        end
        default: st_ff <= H_IDLE;
      endcase
    end
  end
endmodule // afe_host_end
`default_nettype wire

// ### test/crc_link_checker.sv
`default_nettype none
module crc_link_checker (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic chip_select_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso,
  input wire logic data_ready_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] high_cnt_ff;
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rstn);
  // Length so far of the ready pulse in progress.
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      high_cnt_ff <= 4'h0;
    end else begin
      high_cnt_ff <= data_ready_out ? high_cnt_ff + 4'h1 : 4'h0;
    end
  end
  AST_DATA_READY_OUT_MIN: assert property ($rose(data_ready_out) |-> data_ready_out[*2])
    else $error("ready pulse too short");
  AST_DATA_READY_OUT_WIDTH: assert property ($fell(data_ready_out) |-> (high_cnt_ff == 4'h2 || high_cnt_ff == 4'h8))
    else $error("ready pulse width wrong");
  AST_SCLK_IDLE: assert property (chip_select_n |-> !sclk)
    else $error("serial clock runs outside a frame");
  AST_FRAME_START: assert property ($fell(chip_select_n) |-> !sclk ##[1:8] sclk)
    else $error("first serial clock late");
  AST_SCLK_HIGH: assert property ($rose(sclk) |-> sclk[*8] ##1 !sclk)
    else $error("serial clock high phase wrong");
  AST_SCLK_LOW: assert property ($fell(sclk) |-> !sclk[*8])
    else $error("serial clock low phase short");
  AST_CS_GAP: assert property ($rose(chip_select_n) |-> chip_select_n[*3])
    else $error("frame gap too short");
  AST_MOSI_HOLD: assert property (!chip_select_n && sclk |-> $stable(mosi))
    else $error("host data moved while clock high");
  cover property ($fell(data_ready_out) && high_cnt_ff == 4'h8);
  cover property ($rose(miso));
  cover property ($fell(chip_select_n));
endmodule // crc_link_checker
`default_nettype wire

// ### test/afe_spi_command_crc_chan_config_bench.sv
`default_nettype none
module afe_spi_command_crc_chan_config_bench import afe_cmd_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [23:0] m; logic [23:0] v;} note_t;
  logic mclk = 1'b0, rstn = 1'b0, req = 1'b0, conv_valid = 1'b0;
  logic [3:0] conv_chan = 4'h0, cfg_chan = 4'h0;
  logic [15:0] instr = 16'h0000, trim_word = 16'h0000;
  logic [23:0] wdata = 24'h000000, conv_data = 24'h000000, coef_word = 24'h000000;
  logic ready, done, conv_start, high_voltage_source_select, tcc_dis, sel_unused, cs_q, rdy_q;
  logic [2:0] conv_mode, gain_sel, lv_sel;
  logic [5:0] word_idx;
  logic [3:0] ch_ptr, pos_sel, neg_sel, cal_ptr, thr_sel;
  logic [23:0] rdata;
  logic [15:0] cfg0_exp [16];
  logic [15:0] cfg1_exp [16];
  logic [15:0] ck_cmd [3] = '{CMD_CK_CFG, CMD_CK_COEF, CMD_CK_TRIM};
  note_t notes[$];
  int fails = 0, n_compared = 0, cyc = 0, cs_rise_t = 0, rdy_rise_t = 0, rdy_w = 0, rdy_cnt = 0;
  afe_spi_if spi_link();
  afe_host_end i_afe_host_end (.i_mclk(mclk), .i_rstn(rstn), .spi(spi_link), .i_req(req), .i_instr(instr),
    .i_wdata(wdata), .o_ready(ready), .o_done(done), .o_rdata(rdata));
  afe_dev_end i_afe_dev_end (.i_mclk(mclk), .i_rstn(rstn), .spi(spi_link), .i_conv_valid(conv_valid),
    .i_conv_chan(conv_chan), .i_conv_data(conv_data), .i_cfg_chan(cfg_chan), .i_coef_word(coef_word),
    .i_trim_word(trim_word), .o_conv_start(conv_start), .o_conv_mode(conv_mode), .o_word_idx(word_idx),
    .o_ch_ptr(ch_ptr), .o_pos_sel(pos_sel), .o_neg_sel(neg_sel), .o_gain_sel(gain_sel), .o_high_voltage_source_select(high_voltage_source_select),
    .o_lv_sel(lv_sel), .o_tcc_dis(tcc_dis), .o_cal_ptr(cal_ptr), .o_thr_sel(thr_sel), .o_sel_unused(sel_unused));
  crc_link_checker i_crc_link_checker (.i_mclk(mclk), .i_rstn(rstn), .chip_select_n(spi_link.chip_select_n),
    .sclk(spi_link.sclk), .mosi(spi_link.mosi), .miso(spi_link.miso), .data_ready_out(spi_link.data_ready_out));

  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] seen);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    if (fails == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Reference checksum: folds the low n bits of a word in, most significant bit first.
  function automatic logic [15:0] fold(input logic [15:0] c, input logic [23:0] w, input int n);
    for (int i = n - 1; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ w[i]) ? CRC_POLY : 16'h0000);
    return c;
  endfunction

  task automatic wait_for(ref logic s, input logic lvl, input int lim);
    for (int n = 0; n < lim; n++) begin
      @(posedge mclk);
      #1;
      if (s === lvl) return;
    end
    fails++;
    $display("Error handshake expected %b seen %b", lvl, s);
  endtask

  task automatic xfer(input logic [15:0] ins, input logic [23:0] wd, input logic [23:0] m, input logic [23:0] v);
    wait_for(ready, 1'b1, 40);
    @(posedge mclk);
    req <= 1'b1;
    instr <= ins;
    wdata <= wd;
    notes.push_back({m, v});
    wait_for(ready, 1'b0, 20);
    @(posedge mclk);
    req <= 1'b0;
    wait_for(done, 1'b1, 2000);
  endtask

  initial begin
    forever #5 mclk = ~mclk;
  end

  // Scoreboard side: pops one note per finished transfer and times the ready pulses.
  always @(posedge mclk) begin
    note_t nt;
    cyc++;
    if (done === 1'b1 && notes.size() > 0) begin
      nt = notes.pop_front();
      if (nt.m !== 24'h0) check("read data", nt.v & nt.m, rdata & nt.m);
    end
    if (spi_link.chip_select_n === 1'b1 && cs_q === 1'b0) cs_rise_t = cyc;
    if (spi_link.data_ready_out === 1'b1) begin
      if (rdy_q !== 1'b1) rdy_rise_t = cyc;
      rdy_cnt++;
    end else if (rdy_q === 1'b1) begin
      rdy_w = rdy_cnt;
      rdy_cnt = 0;
    end
    cs_q = spi_link.chip_select_n;
    rdy_q = spi_link.data_ready_out;
  end

  initial begin
    repeat (90000) @(posedge mclk);
    fails++;
    conclude();
  end

  initial begin
    logic [15:0] e;
    logic [3:0] cv;
    logic [23:0] d;
    void'($urandom(32'hC0EE));
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    for (int c = 0; c < 16; c++) begin
      cv = 4'(c);
      d = 24'($urandom());
      cfg0_exp[c] = {cv, ~cv, cv[2:0], cv[3], cv[2:0], d[0]};
      cfg1_exp[c] = d[23:8];
      xfer(INSTR_WR | 16'(c), 0, 0, 0);
      check("channel pointer", 24'(c), {20'h0, ch_ptr});
      xfer(INSTR_WR | 16'(ADDR_CFG0), {8'h0, cfg0_exp[c]}, 0, 0);
      xfer(INSTR_WR | 16'(ADDR_CFG1), {8'h0, cfg1_exp[c]}, 0, 0);
    end
    for (int c = 15; c >= 0; c--) begin
      e = cfg0_exp[c];
      xfer(INSTR_WR | 16'(c), 0, 0, 0);
      xfer(INSTR_RD | 16'(ADDR_STATUS), 0, 24'h00000F, 24'(c));
      xfer(INSTR_RD | 16'(ADDR_CFG0), 0, 24'h00FFFF, {8'h0, e});
      xfer(INSTR_RD | 16'(ADDR_CFG1), 0, 24'h00FF00, {8'h0, cfg1_exp[c]});
      @(posedge mclk);
      cfg_chan <= 4'(c);
      repeat (3) @(posedge mclk);
      check("fields", {cfg1_exp[c][15:8], e}, {cal_ptr, thr_sel, pos_sel, neg_sel, gain_sel, high_voltage_source_select, lv_sel, tcc_dis});
      check("unused select", {23'h0, e[4] ? (e[15] | e[11]) : (e[3:1] > 3'h5)}, {23'h0, sel_unused});
    end
    for (int k = 0; k < 4; k++) begin
      if (k == 3) xfer(INSTR_WR | 16'(ADDR_SYSCFG0), 24'h008000, 0, 0);
      @(posedge mclk);
      coef_word <= 24'($urandom());
      trim_word <= 16'($urandom());
      xfer(ck_cmd[k % 3], 0, 0, 0);
      e = CRC_INIT;
      for (int i = 0; i < 48; i++) begin
        if (k % 3 == 1) e = fold(e, coef_word, 24);
        if (k % 3 == 2 && i < 16) e = fold(e, {8'h0, trim_word}, 16);
        if (k % 3 == 0 && i < 33) begin
          d = {8'h0, i < 16 ? cfg0_exp[i] : i < 32 ? cfg1_exp[i % 16] : 16'(k / 3) << 15};
          e = fold(e, d, 16);
        end
      end
      repeat (70) @(posedge mclk);
      check("ready latency", 24'h1, {23'h0, (rdy_rise_t - cs_rise_t) inside {[-8:64]}});
      check("ready width", {20'h0, k == 3 ? DATA_READY_OUT_LONG : DATA_READY_OUT_SHORT}, 24'(rdy_w));
      check("word index", 24'(k % 3 == 1 ? 48 : k % 3 == 2 ? 16 : 33), {18'h0, word_idx});
      xfer(INSTR_RD | 16'(ADDR_CK_CFG + 13'(k % 3)), 0, 24'h00FFFF, {8'h0, e});
    end
    for (int m = 0; m < 5; m++) begin
      cv = 4'($urandom());
      d = 24'($urandom());
      fork
        xfer(INSTR_RD | 16'(m), 0, 24'hFFFFFF, d);
        begin
          wait_for(conv_start, 1'b1, 600);
          check("conversion mode", 24'(m), {21'h0, conv_mode});
          repeat (20) @(posedge mclk);
          conv_chan <= cv;
          conv_data <= d;
          conv_valid <= 1'b1;
          @(posedge mclk);
          conv_valid <= 1'b0;
        end
      join
      xfer(INSTR_RD | 16'(ADDR_DATA0) | 16'(cv), 0, 24'hFFFFFF, d);
    end
    conclude();
  end
endmodule // afe_spi_command_crc_chan_config_bench
`default_nettype wire
